// ===== inc/pbc_pkg.sv
/*
 * pbc_pkg: constants, types and helpers shared by the power budget
 * capability register block and its value store.
 * assumes: a 32-bit APB slave on one clock, byte addresses as printed.
 */
package pbc_pkg;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam int unsigned PBC_ADDR_W        = 12;
    localparam logic [11:0] PBC_OFS_HEADER    = 12'h280;
    localparam logic [11:0] PBC_OFS_SELECT    = 12'h284;
    localparam logic [11:0] PBC_OFS_READBACK  = 12'h288;
    localparam logic [11:0] PBC_OFS_ALLOC     = 12'h28c;
    localparam logic [11:0] PBC_OFS_VALUE_LO  = 12'h300;
    localparam logic [11:0] PBC_OFS_VALUE_HI  = 12'h31c;
    localparam logic [11:0] PBC_OFS_SW_CTRL   = 12'h404;

    // ------------------------------------------------------------------
    // field layout and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PBC_ID_LSB        = 0;
    localparam int unsigned PBC_ID_W          = 16;
    localparam int unsigned PBC_REV_LSB       = 16;
    localparam int unsigned PBC_REV_W         = 4;
    localparam int unsigned PBC_NEXT_LSB      = 20;
    localparam int unsigned PBC_NEXT_W        = 12;
    localparam int unsigned PBC_SEL_W         = 8;
    localparam int unsigned PBC_ALLOC_BIT     = 0;
    localparam int unsigned PBC_VUNLOCK_BIT   = 0;
    localparam int unsigned PBC_CUNLOCK_BIT   = 1;
    localparam int unsigned PBC_NUM_VALUES    = 8;
    localparam logic [7:0]  PBC_SEL_MAX       = 8'h07;
    localparam logic [31:0] PBC_HEADER_RST    = 32'h0000_0000;
    localparam logic [7:0]  PBC_SELECT_RST    = 8'h00;
    localparam logic [31:0] PBC_VALUE_RST     = 32'h0000_0000;
    localparam logic [31:0] PBC_ZERO          = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PBC_REG_HEADER   = 3'b000,
        PBC_REG_SELECT   = 3'b001,
        PBC_REG_READBACK = 3'b010,
        PBC_REG_ALLOC    = 3'b011,
        PBC_REG_VALUE    = 3'b100,
        PBC_REG_SW_CTRL  = 3'b101,
        PBC_REG_NONE     = 3'b111
    } pbc_reg_t;

    typedef enum logic [0:0] {
        PBC_PH_IDLE   = 1'b0,
        PBC_PH_ACCESS = 1'b1
    } pbc_phase_t;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
    } pbc_apb_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } pbc_apb_rsp_t;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic pbc_reg_t pbc_decode(input logic [11:0] addr);
        pbc_reg_t r;
        r = PBC_REG_NONE;
        if (addr[1:0] == 2'b00) begin
            if (addr == PBC_OFS_HEADER) begin
                r = PBC_REG_HEADER;
            end else if (addr == PBC_OFS_SELECT) begin
                r = PBC_REG_SELECT;
            end else if (addr == PBC_OFS_READBACK) begin
                r = PBC_REG_READBACK;
            end else if (addr == PBC_OFS_ALLOC) begin
                r = PBC_REG_ALLOC;
            end else if (addr >= PBC_OFS_VALUE_LO && addr <= PBC_OFS_VALUE_HI) begin
                r = PBC_REG_VALUE;
            end else if (addr == PBC_OFS_SW_CTRL) begin
                r = PBC_REG_SW_CTRL;
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] pbc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        logic [31:0] m;
        m = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return m;
    endfunction

endpackage

// ===== hdl/pbc_value_store.sv
/*
 * pbc_value_store: the eight budget value words and the selector mux
 * that feeds the readback register.
 * assumes: write strobe comes from the APB access edge of the parent.
 */
`timescale 1ns/1ns
module pbc_value_store
    import pbc_pkg::*;
#(
    parameter int unsigned NUM_WORDS = PBC_NUM_VALUES
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        wr_en_in,
    input  wire logic [2:0]  wr_idx_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic [3:0]  wr_strb_in,
    input  wire logic        unlock_in,
    input  wire logic [7:0]  select_in,
    output logic      [31:0] word_out,
    output logic      [31:0] readback_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_WORDS-1:0][31:0] words;
    } pbc_store_t;

    pbc_store_t state_ff;
    pbc_store_t nxt_state;

    // ------------------------------------------------------------------
    // write path
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        if (wr_en_in && unlock_in) begin                               // RULE7
            nxt_state.words[wr_idx_in] =
                pbc_merge(state_ff.words[wr_idx_in], wr_data_in, wr_strb_in);
        end
    end

    // no sticky domain here: words clear on the one reset there is
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // read paths
    // ------------------------------------------------------------------
    always_comb begin
        word_out = state_ff.words[wr_idx_in];
        if (select_in > PBC_SEL_MAX) begin                             // RULE5
            readback_out = PBC_ZERO;
        end else begin
            readback_out = state_ff.words[select_in[2:0]];             // RULE6
        end
    end

endmodule

// ===== hdl/pbc_regs.sv
/*
 * pbc_regs: APB register block of the power budgeting capability:
 * header, value select, readback, allocation flag, switch control
 * unlock bits and the eight budget value words.
 * assumes: APB master on CLK_IN, zero wait states, synchronous reset.
 */
// Implementation choice: register access over APB.
// Notes on behaviour
// RULE1: header bits 15:0 hold the capability id; four marks power budgeting.
// RULE2: header bits 19:16 hold the capability version; one means version 1.
// RULE3: loader should write id and version from EEPROM; both reset to zero.
// RULE4: an 8-bit selector picks which budget word the readback shows.
// RULE5: selector above seven makes the readback return zero.
// RULE6: readback returns the budget word chosen by selector zero to seven.
// RULE7: budget words take writes only while the unlock bit is set.
// RULE8: select bits 31:8 read zero and ignore writes.
`timescale 1ns/1ns
module pbc_regs
    import pbc_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             SYSTEM_ALLOCATED_OUT,
    output logic             VALUE_UNLOCK_OUT
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pbc_phase_t   phase;
        logic [31:0]  header;
        logic [7:0]   selector;
        logic         sys_alloc;
        logic         value_unlock;
        logic         cfg_unlock;
        pbc_apb_rsp_t rsp;
    } pbc_state_t;

    pbc_state_t   state_ff;
    pbc_state_t   nxt_state;
    pbc_apb_req_t req;
    pbc_reg_t     dec;
    logic [31:0]  value_word;
    logic [31:0]  readback;
    logic [31:0]  rd_mux;
    logic         val_wr;

    always_comb begin
        req.sel    = PSEL_IN;
        req.enable = PENABLE_IN;
        req.write  = PWRITE_IN;
        req.addr   = PADDR_IN;
        req.wdata  = PWDATA_IN;
        req.strb   = PSTRB_IN;
    end

    assign dec = pbc_decode(req.addr);

    // ------------------------------------------------------------------
    // budget value words
    // ------------------------------------------------------------------
    // writes land on the access edge, same moment as every other register
    assign val_wr = (state_ff.phase == PBC_PH_ACCESS) && req.sel && req.enable
                    && req.write && (dec == PBC_REG_VALUE);

    pbc_value_store #(
        .NUM_WORDS (PBC_NUM_VALUES)
    ) u_store (
        .clk_in       (CLK_IN),
        .rst_in       (RST_IN),
        .wr_en_in     (val_wr),
        .wr_idx_in    (req.addr[4:2]),
        .wr_data_in   (req.wdata),
        .wr_strb_in   (req.strb),
        .unlock_in    (state_ff.value_unlock),
        .select_in    (state_ff.selector),                              // RULE4
        .word_out     (value_word),
        .readback_out (readback)
    );

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_mux = PBC_ZERO;
        case (dec)
            PBC_REG_HEADER: begin
                rd_mux = state_ff.header;                       // RULE1 RULE2
            end
            PBC_REG_SELECT: begin
                rd_mux = {24'h000000, state_ff.selector};               // RULE8
            end
            PBC_REG_READBACK: begin
                rd_mux = readback;                                      // RULE6
            end
            PBC_REG_ALLOC: begin
                rd_mux[PBC_ALLOC_BIT] = state_ff.sys_alloc;
            end
            PBC_REG_VALUE: begin
                rd_mux = value_word;
            end
            PBC_REG_SW_CTRL: begin
                rd_mux[PBC_VUNLOCK_BIT] = state_ff.value_unlock;
                rd_mux[PBC_CUNLOCK_BIT] = state_ff.cfg_unlock;
            end
            default: begin
                rd_mux = PBC_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // bus sequencer and register writes
    // ------------------------------------------------------------------
    // setup edge captures read data and raises ready; the access edge
    // commits the write, so pready is high for exactly one cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff.phase)
            PBC_PH_IDLE: begin
                nxt_state.rsp = '0;
                if (req.sel && !req.enable) begin
                    nxt_state.phase      = PBC_PH_ACCESS;
                    nxt_state.rsp.ready  = 1'b1;
                    nxt_state.rsp.slverr = (dec == PBC_REG_NONE);
                    nxt_state.rsp.rdata  = req.write ? PBC_ZERO : rd_mux;
                end
            end
            PBC_PH_ACCESS: begin
                nxt_state.phase = PBC_PH_IDLE;
                nxt_state.rsp   = '0;
                if (req.sel && req.enable && req.write) begin
                    case (dec)
                        PBC_REG_HEADER: begin
                            // locked fields: loader unlocks, writes, relocks
                            if (state_ff.cfg_unlock) begin              // RULE3
                                nxt_state.header = pbc_merge(state_ff.header,
                                                             req.wdata,
                                                             req.strb);
                            end
                        end
                        PBC_REG_SELECT: begin
                            if (req.strb[0]) begin                      // RULE8
                                nxt_state.selector = req.wdata[7:0];    // RULE4
                            end
                        end
                        PBC_REG_ALLOC: begin
                            if (state_ff.cfg_unlock && req.strb[0]) begin
                                nxt_state.sys_alloc = req.wdata[PBC_ALLOC_BIT];
                            end
                        end
                        PBC_REG_SW_CTRL: begin
                            if (req.strb[0]) begin
                                nxt_state.value_unlock = req.wdata[PBC_VUNLOCK_BIT];
                                nxt_state.cfg_unlock   = req.wdata[PBC_CUNLOCK_BIT];
                            end
                        end
                        default: begin
                            nxt_state.phase = PBC_PH_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                nxt_state.phase = PBC_PH_IDLE;
                nxt_state.rsp   = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            state_ff.phase        <= PBC_PH_IDLE;
            state_ff.header       <= PBC_HEADER_RST;                    // RULE3
            state_ff.selector     <= PBC_SELECT_RST;
            state_ff.sys_alloc    <= 1'b0;
            state_ff.value_unlock <= 1'b0;
            state_ff.cfg_unlock   <= 1'b0;
            state_ff.rsp          <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign PRDATA_OUT           = state_ff.rsp.rdata;
    assign PREADY_OUT           = state_ff.rsp.ready;
    assign PSLVERR_OUT          = state_ff.rsp.slverr;
    assign SYSTEM_ALLOCATED_OUT = state_ff.sys_alloc;
    assign VALUE_UNLOCK_OUT     = state_ff.value_unlock;

endmodule

// ===== dv/pbc_regs_assertions.sv
/*
 * pbc_regs_checker: port-level assertions for the power budget register block.
 * assumes: bound to pbc_regs, one clock, synchronous active-high reset.
 */
`timescale 1ns/1ns
module pbc_regs_checker
    import pbc_pkg::*;
(
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0]  PSTRB_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        SYSTEM_ALLOCATED_OUT,
    input wire logic        VALUE_UNLOCK_OUT
);
    // ------------------------------------------------------------------
    // selector shadow, updated at the write commit edge
    // ------------------------------------------------------------------
    logic [7:0] sel_ff;
    logic       setup;
    logic       commit;

    assign setup  = PSEL_IN && !PENABLE_IN;
    assign commit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            sel_ff <= PBC_SELECT_RST;
        end else if (commit && PADDR_IN == PBC_OFS_SELECT && PSTRB_IN[0]) begin
            sel_ff <= PWDATA_IN[7:0];
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    ready_after_setup_a: assert property (setup |=> PREADY_OUT)
        else $error("ready missing after setup");
    ready_single_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held longer than one cycle");
    rdata_idle_a: assert property (!PREADY_OUT |-> PRDATA_OUT == PBC_ZERO)
        else $error("read data not zero outside access");
    err_with_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    misalign_err_a: assert property (setup && PADDR_IN[1:0] != 2'b00 |=> PSLVERR_OUT)
        else $error("misaligned access not refused");
    sel_upper_zero_a: assert property (
        setup && !PWRITE_IN && PADDR_IN == PBC_OFS_SELECT |=> PRDATA_OUT[31:8] == 24'h000000)
        else $error("select upper bits not zero");
    readback_zero_a: assert property (
        setup && !PWRITE_IN && PADDR_IN == PBC_OFS_READBACK && sel_ff > PBC_SEL_MAX
        |=> PRDATA_OUT == PBC_ZERO) else $error("readback not zero for large selector");
    unlock_follow_a: assert property (
        commit && PADDR_IN == PBC_OFS_SW_CTRL && PSTRB_IN[0]
        |=> VALUE_UNLOCK_OUT == $past(PWDATA_IN[PBC_VUNLOCK_BIT]))
        else $error("value unlock does not follow write");
    reset_quiet_a: assert property (disable iff (1'b0) RST_IN |=> !PREADY_OUT
        && PRDATA_OUT == PBC_ZERO && !VALUE_UNLOCK_OUT && !SYSTEM_ALLOCATED_OUT)
        else $error("outputs not quiet after reset");
endmodule

bind pbc_regs pbc_regs_checker u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .SYSTEM_ALLOCATED_OUT(SYSTEM_ALLOCATED_OUT), .VALUE_UNLOCK_OUT(VALUE_UNLOCK_OUT));

// ===== dv/power_budget_capability_regs_tb_top.sv
/*
 * power_budget_capability_regs_tb_top: directed APB bench for pbc_regs.
 * assumes: checker bound separately; no other bus master on the block.
 */
`timescale 1ns/1ns
module power_budget_capability_regs_tb_top;
    import pbc_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, alloc, unlock, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [7:0]  big [3] = '{8'h08, 8'h80, 8'hff};
    int          num_errors, compares;

    pbc_regs dut (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .SYSTEM_ALLOCATED_OUT(alloc), .VALUE_UNLOCK_OUT(unlock));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] val(input logic [2:0] i);
        return 32'hc0de_0000 | {29'h0, i};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // psel stays up so back-to-back transfers need no extra edge; idle drops it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // no local limit: a ready that never comes is left to the watchdog
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
    endtask

    task automatic wrw(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask

    task automatic rdw(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask

    task automatic idle;
        psel <= 1'b0;
        @(posedge clk);
    endtask

    task automatic end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0; num_errors = 0; compares = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rdw(PBC_OFS_HEADER); chk(rd, PBC_HEADER_RST, "header reset");
        rdw(PBC_OFS_SELECT); chk(rd, 32'h0, "select reset");
        wrw(PBC_OFS_HEADER, 32'habc1_0004);
        rdw(PBC_OFS_HEADER); chk(rd, 32'h0, "header locked");
        wrw(PBC_OFS_SW_CTRL, 32'h3); idle; chk({31'h0, unlock}, 32'h1, "unlock");
        wrw(PBC_OFS_HEADER, 32'habc1_0004);
        rdw(PBC_OFS_HEADER); chk({16'h0, rd[15:0]}, 32'h4, "cap id");
        chk({28'h0, rd[19:16]}, 32'h1, "cap version");
        chk(rd, 32'habc1_0004, "header word");
        wrw(PBC_OFS_ALLOC, 32'h1); idle; chk({31'h0, alloc}, 32'h1, "allocated");
        for (int i = 0; i < 8; i++) wrw(PBC_OFS_VALUE_LO + 12'(4 * i), val(3'(i)));
        for (int i = 0; i < 8; i++) begin
            wrw(PBC_OFS_SELECT, 32'(i));
            rdw(PBC_OFS_READBACK); chk(rd, val(3'(i)), "readback word");
        end
        for (int i = 0; i < 3; i++) begin
            wrw(PBC_OFS_SELECT, {24'h0, big[i]});
            rdw(PBC_OFS_READBACK); chk(rd, 32'h0, "readback large sel");
        end
        wrw(PBC_OFS_SELECT, 32'hffff_ff03);
        rdw(PBC_OFS_SELECT); chk(rd, 32'h3, "select reserved bits");
        wrw(PBC_OFS_READBACK, 32'h1234_5678); chk({31'h0, err}, 32'h0, "readback wr err");
        rdw(PBC_OFS_READBACK); chk(rd, val(3'd3), "readback kept");
        apb(1'b1, PBC_OFS_VALUE_LO + 12'h008, 32'hffff_ffff, 4'b0010);
        wrw(PBC_OFS_SELECT, 32'h2);
        rdw(PBC_OFS_READBACK); chk(rd, val(3'd2) | 32'h0000_ff00, "lane merge");
        // relock, then a value write must be dropped
        wrw(PBC_OFS_SW_CTRL, 32'h0); idle; chk({31'h0, unlock}, 32'h0, "relock");
        wrw(PBC_OFS_VALUE_LO + 12'h00c, 32'h0);
        rdw(PBC_OFS_VALUE_LO + 12'h00c); chk(rd, val(3'd3), "locked word");
        rdw(12'h290); chk({31'h0, err}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
        wrw(12'h286, 32'h1); chk({31'h0, err}, 32'h1, "misaligned err");
        idle;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdw(PBC_OFS_VALUE_LO); chk(rd, PBC_VALUE_RST, "word after reset");
        rdw(PBC_OFS_HEADER); chk(rd, PBC_HEADER_RST, "header after reset");
        idle;
        end_sim;
    end

    initial begin
        #200000;
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_sim;
    end
endmodule
